//--- hw/tcp_defines.svh
// register offsets, field positions, free-running count limits and sizes of the timer block
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

`define TCP_NCH          2
`define TCP_AW           4
`define TCP_DW           16
`define TCP_NSYNC        5

// synchroniser lanes
`define TCP_SY_CMP       2
`define TCP_SY_FIX       3
`define TCP_SY_EXT       4

// register offsets
`define TCP_A_STATUS     4'h0
`define TCP_A_COUNT      4'h1
`define TCP_A_MODULO     4'h2
`define TCP_A_CH_BASE    4'h3
`define TCP_A_OPTIONS    4'h7

// timer_status_control fields
`define TCP_SC_FLAG      7
`define TCP_SC_IE        6
`define TCP_SC_CENTER_ALIGNED_PWM      5
`define TCP_SC_CLK_HI    4
`define TCP_SC_CLK_LO    3
`define TCP_SC_PS_HI     2
`define TCP_SC_PS_LO     0

// channel control fields
`define TCP_CC_FLAG      7
`define TCP_CC_IE        6
`define TCP_CC_MODE_HI   5
`define TCP_CC_MODE_LO   4
`define TCP_CC_EL_HI     3
`define TCP_CC_EL_LO     2

// system_options_two field
`define TCP_OPT_ROUTE    0

`define TCP_CNT_FREE_LO  16'h0000
`define TCP_CNT_FREE_HI  16'hffff

`endif

//--- hw/tcp_pkg.sv
// types shared by the timer block
`include "tcp_defines.svh"
package tcp_pkg;

  typedef enum logic [1:0] {
    CLK_OFF   = 2'b00,
    CLK_BUS   = 2'b01,
    CLK_FIXED = 2'b10,
    CLK_EXT   = 2'b11
  } tcp_clk_src_e;

  typedef enum logic [1:0] {
    FN_CAP  = 2'b00,
    FN_CMP  = 2'b01,
    FN_EDGE_ALIGNED_PWM = 2'b10,
    FN_CENTER_ALIGNED_PWM = 2'b11
  } tcp_func_e;

  typedef struct packed {
    logic [`TCP_DW-1:0] value;
    logic [1:0]         mode;
    logic [1:0]         edge_lvl;
    logic               ie;
    logic               flag;
    logic               pin;
  } tcp_chan_s;

  typedef struct packed {
    tcp_chan_s [`TCP_NCH-1:0] ch;
    logic [`TCP_DW-1:0]       cnt;
    logic                     cnt_down;
    logic [`TCP_DW-1:0]       modulo;
    logic [6:0]               pre;
    logic                     ovf_flag;
    logic                     ovf_ie;
    logic                     center_aligned_pwm;
    tcp_clk_src_e             clk_src;
    logic [2:0]               ps;
    logic                     route;
    logic [`TCP_DW-1:0]       rdata;
  } tcp_state_s;

  typedef struct packed {
    logic [`TCP_NSYNC-1:0] s1;
    logic [`TCP_NSYNC-1:0] s2;
    logic [`TCP_NSYNC-1:0] s3;
    logic [`TCP_NSYNC-1:0] lvl;
    logic [`TCP_NSYNC-1:0] rise;
    logic [`TCP_NSYNC-1:0] fall;
  } tcp_sync_s;

endpackage

//--- hw/tcp_pin_sync.sv
// three-stage synchroniser with agreement filter and edge pulses for external inputs
`timescale 1ns/1ps
`include "tcp_defines.svh"
module tcp_pin_sync
(
  input  wire logic                  core_clk_in,
  input  wire logic                  resetn_in,
  input  wire logic [`TCP_NSYNC-1:0] async_in,
  output logic      [`TCP_NSYNC-1:0] level_out,
  output logic      [`TCP_NSYNC-1:0] rise_out,
  output logic      [`TCP_NSYNC-1:0] fall_out
);

  tcp_pkg::tcp_sync_s st_r;
  tcp_pkg::tcp_sync_s st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.s1   = async_in;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    // a level only moves once stages two and three agree, so one-cycle glitches never count
    for (int i = 0; i < `TCP_NSYNC; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
      begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
    st_nxt.rise = st_nxt.lvl & ~st_r.lvl;
    st_nxt.fall = ~st_nxt.lvl & st_r.lvl;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.lvl;
  assign rise_out  = st_r.rise;
  assign fall_out  = st_r.fall;

endmodule

//--- hw/tcp_timer.sv
// 16-bit timer with per-channel capture, compare and pwm plus module-wide center-aligned pwm
`timescale 1ns/1ps
`include "tcp_defines.svh"
module tcp_timer
(
  input  wire logic                core_clk_in,
  input  wire logic                resetn_in,
  input  wire logic [`TCP_AW-1:0]  addr_in,
  input  wire logic [`TCP_DW-1:0]  wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [`TCP_DW-1:0]  rdata_out,
  input  wire logic                debug_active_in,
  input  wire logic                fixed_clk_in,
  input  wire logic                external_clock_pin_in,
  input  wire logic                comparator_in,
  input  wire logic [`TCP_NCH-1:0] channel_pin_in,
  output logic      [`TCP_NCH-1:0] channel_pin_out,
  output logic      [`TCP_NCH-1:0] channel_pin_oe_out,
  output logic                     ovf_irq_out,
  output logic      [`TCP_NCH-1:0] ch_irq_out
);

  tcp_pkg::tcp_state_s   st_r;
  tcp_pkg::tcp_state_s   st_nxt;
  logic [`TCP_NSYNC-1:0] sy_in;
  logic [`TCP_NSYNC-1:0] sy_rise;
  logic [`TCP_NSYNC-1:0] sy_fall;

  // prescale mask: low ps bits of the prescaler must all be one for a tick
  function automatic logic [6:0] ps_mask(input logic [2:0] ps);
    logic [7:0] full;
    full    = 8'h01 << ps;
    ps_mask = 7'(full - 8'h01);
  endfunction

  function automatic logic is_free(input logic [`TCP_DW-1:0] m);
    is_free = (m == `TCP_CNT_FREE_LO) || (m == `TCP_CNT_FREE_HI);
  endfunction

  function automatic tcp_pkg::tcp_func_e chan_func(input logic center_aligned_pwm, input logic [1:0] mode);
    if (center_aligned_pwm)
    begin
      chan_func = tcp_pkg::FN_CENTER_ALIGNED_PWM;
    end
    else if (mode[1])
    begin
      chan_func = tcp_pkg::FN_EDGE_ALIGNED_PWM;
    end
    else if (mode[0])
    begin
      chan_func = tcp_pkg::FN_CMP;
    end
    else
    begin
      chan_func = tcp_pkg::FN_CAP;
    end
  endfunction

  function automatic logic [`TCP_AW-1:0] ch_addr(input int idx, input logic val);
    ch_addr = `TCP_AW'(`TCP_A_CH_BASE + 2 * idx + int'(val));
  endfunction

  // channel pins, comparator and both clock sources share one synchroniser bank
  always_comb
  begin
    sy_in                = '0;
    sy_in[`TCP_NCH-1:0]  = channel_pin_in;
    sy_in[`TCP_SY_CMP]   = comparator_in;
    sy_in[`TCP_SY_FIX]   = fixed_clk_in;
    sy_in[`TCP_SY_EXT]   = external_clock_pin_in;
  end

  tcp_pin_sync u_sync
  (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .async_in    (sy_in),
    .level_out   (),
    .rise_out    (sy_rise),
    .fall_out    (sy_fall)
  );

  always_comb
  begin
    logic               src_tick;
    logic               cnt_tick;
    logic               step_up;
    logic               wr_ctl;
    logic               hit;
    logic               cap_rise;
    logic               cap_fall;
    logic [6:0]         mask;
    logic [`TCP_DW-1:0] limit;
    logic [`TCP_DW-1:0] nc;
    tcp_pkg::tcp_func_e fn;
    src_tick = 1'b0;
    cnt_tick = 1'b0;
    step_up  = 1'b0;
    wr_ctl   = 1'b0;
    hit      = 1'b0;
    cap_rise = 1'b0;
    cap_fall = 1'b0;
    mask     = ps_mask(st_r.ps);
    limit    = is_free(st_r.modulo) ? `TCP_CNT_FREE_HI : st_r.modulo;
    nc       = st_r.cnt;
    fn       = tcp_pkg::FN_CAP;
    st_nxt   = st_r;
    // read data stand for exactly the cycle after the strobe
    st_nxt.rdata = '0;

    // register writes first, so that hardware events below win over a flag clear
    if (wr_in)
    begin
      case (addr_in)
        `TCP_A_STATUS:
        begin
          st_nxt.ovf_ie  = wdata_in[`TCP_SC_IE];
          st_nxt.center_aligned_pwm    = wdata_in[`TCP_SC_CENTER_ALIGNED_PWM];
          st_nxt.clk_src = tcp_pkg::tcp_clk_src_e'(wdata_in[`TCP_SC_CLK_HI:`TCP_SC_CLK_LO]);
          st_nxt.ps      = wdata_in[`TCP_SC_PS_HI:`TCP_SC_PS_LO];
          if (wdata_in[`TCP_SC_FLAG])
          begin
            st_nxt.ovf_flag = 1'b0;
          end
        end
        `TCP_A_MODULO:
        begin
          st_nxt.modulo = wdata_in;
        end
        `TCP_A_OPTIONS:
        begin
          st_nxt.route = wdata_in[`TCP_OPT_ROUTE];
        end
        default:
        begin
          st_nxt.route = st_r.route;
        end
      endcase
    end

    // source select and prescaler; debug freezes the tick
    case (st_r.clk_src)
      tcp_pkg::CLK_BUS:   src_tick = 1'b1;
      tcp_pkg::CLK_FIXED: src_tick = sy_rise[`TCP_SY_FIX];
      tcp_pkg::CLK_EXT:   src_tick = sy_rise[`TCP_SY_EXT];
      default:            src_tick = 1'b0;
    endcase
    src_tick = src_tick && !debug_active_in;
    cnt_tick = src_tick && ((st_r.pre & mask) == mask);
    if (src_tick)
    begin
      st_nxt.pre = st_r.pre + 7'h01;
    end

    step_up = !st_r.cnt_down;
    if (cnt_tick)
    begin
      if (st_r.center_aligned_pwm)
      begin
        // up to the modulo, then down to zero; terminal count is the return to zero
        if (step_up)
        begin
          nc = st_r.cnt + 16'h0001;
          if (nc >= limit)
          begin
            st_nxt.cnt_down = 1'b1;
          end
        end
        else
        begin
          nc = st_r.cnt - 16'h0001;
          if (nc == 16'h0000)
          begin
            st_nxt.cnt_down = 1'b0;
            st_nxt.ovf_flag = 1'b1;
          end
        end
      end
      else if (st_r.cnt == limit)
      begin
        nc              = 16'h0000;
        st_nxt.ovf_flag = 1'b1;
      end
      else
      begin
        nc = st_r.cnt + 16'h0001;
      end
      st_nxt.cnt = nc;
    end

    // a counter write only resets, reads leave the sequence alone
    if (wr_in && (addr_in == `TCP_A_COUNT))
    begin
      st_nxt.cnt      = 16'h0000;
      st_nxt.pre      = 7'h00;
      st_nxt.cnt_down = 1'b0;
    end

    for (int i = 0; i < `TCP_NCH; i++)
    begin
      fn = chan_func(st_r.center_aligned_pwm, st_r.ch[i].mode);
      wr_ctl = wr_in && (addr_in == ch_addr(i, 1'b0));
      if (wr_ctl)
      begin
        st_nxt.ch[i].ie       = wdata_in[`TCP_CC_IE];
        st_nxt.ch[i].mode     = wdata_in[`TCP_CC_MODE_HI:`TCP_CC_MODE_LO];
        st_nxt.ch[i].edge_lvl = wdata_in[`TCP_CC_EL_HI:`TCP_CC_EL_LO];
        if (wdata_in[`TCP_CC_FLAG])
        begin
          st_nxt.ch[i].flag = 1'b0;
        end
      end
      if (wr_in && (addr_in == ch_addr(i, 1'b1)))
      begin
        st_nxt.ch[i].value = wdata_in;
      end

      // channel 0 may listen to the comparator instead of its pin
      if ((i == 0) && st_r.route)
      begin
        cap_rise = sy_rise[`TCP_SY_CMP];
        cap_fall = sy_fall[`TCP_SY_CMP];
      end
      else
      begin
        cap_rise = sy_rise[i];
        cap_fall = sy_fall[i];
      end

      hit = cnt_tick && (nc == st_r.ch[i].value);
      case (fn)
        tcp_pkg::FN_CAP:
        begin
          if ((st_r.ch[i].edge_lvl[0] && cap_rise) || (st_r.ch[i].edge_lvl[1] && cap_fall))
          begin
            st_nxt.ch[i].value = st_r.cnt;
            st_nxt.ch[i].flag  = 1'b1;
          end
        end
        tcp_pkg::FN_CMP:
        begin
          // edge field 0:0 still flags, so pinless channels serve as software timers
          if (hit)
          begin
            st_nxt.ch[i].flag = 1'b1;
            case (st_r.ch[i].edge_lvl)
              2'b01:   st_nxt.ch[i].pin = !st_r.ch[i].pin;
              2'b10:   st_nxt.ch[i].pin = 1'b0;
              2'b11:   st_nxt.ch[i].pin = 1'b1;
              default: st_nxt.ch[i].pin = st_r.ch[i].pin;
            endcase
          end
        end
        tcp_pkg::FN_EDGE_ALIGNED_PWM:
        begin
          if (cnt_tick && (nc == 16'h0000))
          begin
            st_nxt.ch[i].pin = !st_r.ch[i].edge_lvl[0];
          end
          // match after period start so a zero value gives no pulse at all
          if (hit)
          begin
            st_nxt.ch[i].pin  = st_r.ch[i].edge_lvl[0];
            st_nxt.ch[i].flag = 1'b1;
          end
        end
        default:
        begin
          if (hit)
          begin
            st_nxt.ch[i].pin  = step_up ? st_r.ch[i].edge_lvl[0] : !st_r.ch[i].edge_lvl[0];
            st_nxt.ch[i].flag = 1'b1;
          end
        end
      endcase
    end

    if (rd_in)
    begin
      case (addr_in)
        `TCP_A_STATUS:
        begin
          st_nxt.rdata[`TCP_SC_FLAG]                  = st_r.ovf_flag;
          st_nxt.rdata[`TCP_SC_IE]                    = st_r.ovf_ie;
          st_nxt.rdata[`TCP_SC_CENTER_ALIGNED_PWM]                  = st_r.center_aligned_pwm;
          st_nxt.rdata[`TCP_SC_CLK_HI:`TCP_SC_CLK_LO] = st_r.clk_src;
          st_nxt.rdata[`TCP_SC_PS_HI:`TCP_SC_PS_LO]   = st_r.ps;
        end
        `TCP_A_COUNT:   st_nxt.rdata = st_r.cnt;
        `TCP_A_MODULO:  st_nxt.rdata = st_r.modulo;
        `TCP_A_OPTIONS: st_nxt.rdata[`TCP_OPT_ROUTE] = st_r.route;
        default:
        begin
          for (int i = 0; i < `TCP_NCH; i++)
          begin
            if (addr_in == ch_addr(i, 1'b0))
            begin
              st_nxt.rdata[`TCP_CC_FLAG]                      = st_r.ch[i].flag;
              st_nxt.rdata[`TCP_CC_IE]                        = st_r.ch[i].ie;
              st_nxt.rdata[`TCP_CC_MODE_HI:`TCP_CC_MODE_LO]   = st_r.ch[i].mode;
              st_nxt.rdata[`TCP_CC_EL_HI:`TCP_CC_EL_LO]       = st_r.ch[i].edge_lvl;
            end
            if (addr_in == ch_addr(i, 1'b1))
            begin
              st_nxt.rdata = st_r.ch[i].value;
            end
          end
        end
      endcase
    end
  end

  // reset clears every function, so no pin is claimed until software asks
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // pin is claimed only with a clock source, a nonzero edge field and an output function
  always_comb
  begin
    for (int i = 0; i < `TCP_NCH; i++)
    begin
      channel_pin_out[i]    = st_r.ch[i].pin;
      channel_pin_oe_out[i] = (st_r.clk_src != tcp_pkg::CLK_OFF)
                              && (st_r.ch[i].edge_lvl != 2'b00)
                              && (chan_func(st_r.center_aligned_pwm, st_r.ch[i].mode) != tcp_pkg::FN_CAP)
                              && !((i == 0) && st_r.route);
      ch_irq_out[i]         = st_r.ch[i].flag && st_r.ch[i].ie;
    end
  end

  assign ovf_irq_out = st_r.ovf_flag && st_r.ovf_ie;
  assign rdata_out   = st_r.rdata;

endmodule

//--- testbench/tcp_timer_monitor.sv
// port-level assertions for the timer block
`timescale 1ns/1ps
`include "tcp_defines.svh"
module tcp_timer_monitor
(
  input wire logic                core_clk_in,
  input wire logic                resetn_in,
  input wire logic [`TCP_AW-1:0]  addr_in,
  input wire logic [`TCP_DW-1:0]  wdata_in,
  input wire logic                wr_in,
  input wire logic                rd_in,
  input wire logic [`TCP_DW-1:0]  rdata_out,
  input wire logic                debug_active_in,
  input wire logic                fixed_clk_in,
  input wire logic                external_clock_pin_in,
  input wire logic                comparator_in,
  input wire logic [`TCP_NCH-1:0] channel_pin_in,
  input wire logic [`TCP_NCH-1:0] channel_pin_out,
  input wire logic [`TCP_NCH-1:0] channel_pin_oe_out,
  input wire logic                ovf_irq_out,
  input wire logic [`TCP_NCH-1:0] ch_irq_out
);
  // control fields rebuilt from bus writes, so pin ownership can be predicted
  logic [7:0]          sc_r;
  logic [1:0][7:0]     cc_r;
  logic                rt_r;
  logic [`TCP_NCH-1:0] oe_exp;
  wire                 rc = rd_in && addr_in == `TCP_A_COUNT;
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sc_r <= 8'h00;
      cc_r <= 16'h0000;
      rt_r <= 1'b0;
    end
    else if (wr_in)
    begin
      if (addr_in == `TCP_A_STATUS)
        sc_r <= wdata_in[7:0];
      if (addr_in == `TCP_A_CH_BASE)
        cc_r[0] <= wdata_in[7:0];
      if (addr_in == 4'h5)
        cc_r[1] <= wdata_in[7:0];
      if (addr_in == `TCP_A_OPTIONS)
        rt_r <= wdata_in[0];
    end
  end
  always_comb
  begin
    for (int i = 0; i < `TCP_NCH; i++)
      oe_exp[i] = sc_r[4:3] != 2'b00 && cc_r[i][3:2] != 2'b00
                  && (sc_r[5] || cc_r[i][5:4] != 2'b00) && !(i == 0 && rt_r);
  end
  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  rst_quiet_a : assert property (disable iff (1'b0)
    !resetn_in |-> channel_pin_oe_out == 2'b00 && channel_pin_out == 2'b00
    && ch_irq_out == 2'b00 && !ovf_irq_out) else $error("outputs active in reset");
  pin_owner_a : assert property (channel_pin_oe_out == oe_exp)
    else $error("pin enable disagrees with configuration");
  rd_idle_a : assert property (!rd_in |=> rdata_out == 16'h0000)
    else $error("read data outside a read cycle");
  ch_irq_a : assert property ((ch_irq_out & ~{cc_r[1][6], cc_r[0][6]}) == 2'b00)
    else $error("channel request without enable");
  ovf_irq_a : assert property (ovf_irq_out |-> sc_r[6])
    else $error("overflow request without enable");
  count_freeze_a : assert property (rc && debug_active_in ##1 rc |=> $stable(rdata_out))
    else $error("count moved while frozen");
  count_step_a : assert property (rc && !debug_active_in && sc_r[5:0] == 6'b001000
    ##1 rc |=> rdata_out == $past(rdata_out) + 16'h0001 || rdata_out == 16'h0000)
    else $error("count did not step by one");
  count_clear_a : assert property (wr_in && addr_in == `TCP_A_COUNT ##1 rc
    |=> rdata_out == 16'h0000) else $error("count write did not clear");
endmodule
bind tcp_timer tcp_timer_monitor mon (.core_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .debug_active_in, .fixed_clk_in, .external_clock_pin_in, .comparator_in,
  .channel_pin_in, .channel_pin_out, .channel_pin_oe_out, .ovf_irq_out, .ch_irq_out);

//--- testbench/tcp_pins_model.sv
// external circuit model: channel pins, comparator and clock sources
`timescale 1ns/1ps
module tcp_pins_model
(
  input  wire logic       core_clk_in,
  input  wire logic [1:0] lvl_in,
  input  wire logic       cmp_lvl_in,
  input  wire logic [1:0] pin_drv_in,
  input  wire logic [1:0] pin_oe_in,
  output logic      [1:0] pin_out,
  output logic            cmp_out,
  output logic            fixed_out,
  output logic            ext_out
);
  logic [3:0] div_r = 4'h0;
  always_ff @(posedge core_clk_in)
    div_r <= div_r + 4'h1;
  // sources locked to the bus clock so tick counts over a window are exact
  assign fixed_out = div_r[3];
  // external clock at bus/8, inside the bus/4 limit
  assign ext_out = div_r[2];
  assign cmp_out = cmp_lvl_in;
  // the timer's drive wins on the wire, otherwise the outside circuit
  assign pin_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & lvl_in);
endmodule

//--- testbench/test_tcp_timer.sv
// self-checking bench for the timer block
`timescale 1ns/1ps
`include "tcp_defines.svh"
module test_tcp_timer;
  logic                core_clk_in = 1'b0;
  logic                resetn_in = 1'b1;
  logic [`TCP_AW-1:0]  addr_in = 4'h0;
  logic [`TCP_DW-1:0]  wdata_in = 16'h0000;
  logic                wr_in = 1'b0;
  logic                rd_in = 1'b0;
  logic                debug_active_in = 1'b0;
  logic [1:0]          lvl = 2'b00;
  logic                cmp_lvl = 1'b0;
  logic [`TCP_DW-1:0]  rdata_out;
  logic                fixed_clk_in;
  logic                external_clock_pin_in;
  logic                comparator_in;
  logic                ovf_irq_out;
  logic [`TCP_NCH-1:0] channel_pin_in;
  logic [`TCP_NCH-1:0] channel_pin_out;
  logic [`TCP_NCH-1:0] channel_pin_oe_out;
  logic [`TCP_NCH-1:0] ch_irq_out;
  logic [15:0]         q;
  logic [15:0]         q2;
  logic [15:0]         h0;
  logic [15:0]         h1;
  // edge field 01 toggles, 10 drives low, 11 drives high
  logic [15:0]         cmp_exp [4] = '{16'h0000, 16'h0020, 16'h0000, 16'h0040};
  int                  n_fail = 0;
  int                  check_count = 0;
  always #2 core_clk_in = ~core_clk_in;
  tcp_timer uut (.core_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .debug_active_in, .fixed_clk_in, .external_clock_pin_in, .comparator_in, .channel_pin_in,
    .channel_pin_out, .channel_pin_oe_out, .ovf_irq_out, .ch_irq_out);
  tcp_pins_model far (.core_clk_in, .lvl_in(lvl), .cmp_lvl_in(cmp_lvl),
    .pin_drv_in(channel_pin_out), .pin_oe_in(channel_pin_oe_out), .pin_out(channel_pin_in),
    .cmp_out(comparator_in), .fixed_out(fixed_clk_in), .ext_out(external_clock_pin_in));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // tasks start and end in the time step of a rising edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1;
    q = rdata_out;
    @(posedge core_clk_in);
  endtask
  // an access followed with no gap by a read
  task automatic pair(input logic w, input logic [3:0] a, input logic [15:0] d);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= `TCP_A_COUNT;
    #1;
    q = rdata_out;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    q2 = rdata_out;
    @(posedge core_clk_in);
  endtask
  // count reads spaced 256 edges apart, a multiple of every source period
  task automatic rate(input logic [1:0] s, input logic [2:0] p, input logic [15:0] e);
    acc(1'b1, `TCP_A_STATUS, {11'h000, s, p});
    acc(1'b0, `TCP_A_COUNT, 16'h0000);
    q2 = q;
    repeat (254) @(posedge core_clk_in);
    acc(1'b0, `TCP_A_COUNT, 16'h0000);
    chk(q - q2, e);
  endtask
  task automatic meas;
    h0 = 16'h0000;
    h1 = 16'h0000;
    repeat (64)
    begin
      @(posedge core_clk_in);
      #1;
      h0 = h0 + 16'(channel_pin_out[0]);
      h1 = h1 + 16'(channel_pin_out[1]);
    end
    @(posedge core_clk_in);
  endtask
  // move the outside levels, then read and clear the channel 0 flag
  task automatic pulse(input logic [2:0] v, input logic [15:0] c, input logic f);
    {cmp_lvl, lvl} <= v;
    repeat (12) @(posedge core_clk_in);
    acc(1'b0, `TCP_A_CH_BASE, 16'h0000);
    chk(q[7], f);
    acc(1'b1, `TCP_A_CH_BASE, c);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_fail++;
    results();
  end
  initial
  begin
    resetn_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    @(posedge core_clk_in);
    for (int a = 0; a < 16; a++)
    begin
      acc(1'b0, 4'(a), 16'h0000);
      chk(q, 16'h0000);
    end
    for (int p = 0; p < 8; p++)
      rate(2'b01, 3'(p), 16'(256 >> p));
    rate(2'b10, 3'h0, 16'h0010);
    rate(2'b11, 3'h0, 16'h0020);
    rate(2'b00, 3'h0, 16'h0000);
    // an all-zero modulo would pin a plain modulo counter at zero, so it must run free
    acc(1'b1, `TCP_A_MODULO, 16'h0000);
    rate(2'b01, 3'h0, 16'h0100);
    pair(1'b0, `TCP_A_COUNT, 16'h0000);
    chk(q2, q + 16'h0001);
    debug_active_in <= 1'b1;
    pair(1'b0, `TCP_A_COUNT, 16'h0000);
    debug_active_in <= 1'b0;
    chk(q2, q);
    pair(1'b1, `TCP_A_COUNT, 16'hbeef);
    chk(q2, 16'h0000);
    acc(1'b1, `TCP_A_MODULO, 16'h0007);
    acc(1'b1, 4'h4, 16'h0003);
    acc(1'b1, 4'h6, 16'h0006);
    acc(1'b1, `TCP_A_CH_BASE, 16'h0068);
    acc(1'b1, 4'h5, 16'h0064);
    acc(1'b1, `TCP_A_STATUS, 16'h0048);
    acc(1'b1, `TCP_A_COUNT, 16'h0000);
    repeat (16) @(posedge core_clk_in);
    meas();
    chk(h0, 16'h0018);
    chk(h1, 16'h0010);
    chk(ch_irq_out, 2'b11);
    chk(ovf_irq_out, 1'b1);
    acc(1'b1, `TCP_A_CH_BASE, 16'h0028);
    chk(ch_irq_out, 2'b10);
    // clear the flag left over from pwm so only the software compare can set it again
    acc(1'b1, 4'h5, 16'h00d0);
    for (int e = 0; e < 4; e++)
    begin
      acc(1'b1, `TCP_A_CH_BASE, 16'h0090 | 16'(e << 2));
      repeat (16) @(posedge core_clk_in);
      meas();
      if (e != 0)
        chk(h0, cmp_exp[e]);
      acc(1'b0, `TCP_A_CH_BASE, 16'h0000);
      chk(q[7], 1'b1);
    end
    chk(ch_irq_out[1], 1'b1);
    acc(1'b1, `TCP_A_STATUS, 16'h0028);
    acc(1'b1, `TCP_A_MODULO, 16'h0008);
    acc(1'b1, 4'h4, 16'h0005);
    acc(1'b1, 4'h6, 16'h0002);
    acc(1'b1, `TCP_A_CH_BASE, 16'h0008);
    acc(1'b1, 4'h5, 16'h0004);
    acc(1'b1, `TCP_A_COUNT, 16'h0000);
    repeat (40) @(posedge core_clk_in);
    meas();
    chk(h0, 16'h0028);
    chk(h1, 16'h0030);
    acc(1'b1, `TCP_A_STATUS, 16'h0008);
    acc(1'b1, 4'h4, 16'hffff);
    debug_active_in <= 1'b1;
    for (int e = 0; e < 4; e++)
    begin
      acc(1'b1, `TCP_A_CH_BASE, 16'h0080 | 16'(e << 2));
      pulse(3'b001, 16'h0080 | 16'(e << 2), e[0]);
      pulse(3'b000, 16'h0080 | 16'(e << 2), e[1]);
    end
    acc(1'b0, `TCP_A_COUNT, 16'h0000);
    q2 = q;
    acc(1'b0, 4'h4, 16'h0000);
    chk(q, q2);
    acc(1'b0, `TCP_A_STATUS, 16'h0000);
    chk(q[7], 1'b1);
    acc(1'b1, `TCP_A_STATUS, 16'h0088);
    acc(1'b0, `TCP_A_STATUS, 16'h0000);
    chk(q, 16'h0008);
    acc(1'b1, `TCP_A_OPTIONS, 16'h0001);
    acc(1'b1, `TCP_A_CH_BASE, 16'h0084);
    pulse(3'b100, 16'h0084, 1'b1);
    pulse(3'b101, 16'h0084, 1'b0);
    debug_active_in <= 1'b0;
    results();
  end
endmodule
